/* File: core/amm_pkg.sv */
`default_nettype none
package amm_pkg;
    localparam logic [31:0] MBOX_ADDR0 = 32'hff000010;
    localparam logic [31:0] MBOX_ADDR1 = 32'hff000030;
    localparam logic [31:0] ACK_ADDR0 = 32'hff000000;
    localparam logic [31:0] ACK_ADDR1 = 32'hff000020;
    localparam logic [31:0] INT_CTRL_RST = 32'hff000000;
    localparam int MBOX_WORDS = 4;
    localparam int PRIO_LSB = 16;
    localparam int PRIO_MSB = 20;
    localparam int PRIO_FLAG_BIT = 3;
    localparam logic [2:0] ACK_CODE = 3'h4;
    localparam logic [7:0] I0_MSG_SEL = 8'h00;
    localparam int NUM_VECTORS = 248;
    localparam logic [7:0] VEC_LOW = 8'h08;
    typedef enum logic [2:0] {
        AMM_IDLE = 3'b000,
        AMM_READ = 3'b001,
        AMM_ACK = 3'b010,
        AMM_PRIO = 3'b011,
        AMM_ACT = 3'b100
    } amm_state_t;
endpackage
`default_nettype wire

/* File: core/amm_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface amm_if;
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rvalid;
    logic msg_pin;
    modport device (output rd, output wr, output addr, output wdata,
        input rdata, input rvalid, input msg_pin);
    modport other (input rd, input wr, input addr, input wdata,
        output rdata, output rvalid, output msg_pin);
endinterface
`default_nettype wire

/* File: core/amm_device.sv */
`timescale 1ns/1ps
`default_nettype none
module amm_device (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    amm_if.device bus,
    input wire logic processor_index,
    input wire logic mirror_en,
    input wire logic ext_msg_en,
    input wire logic prio_event,
    input wire logic [4:0] prio_event_val,
    input wire logic self_msg,
    input wire logic [31:0] self_msg_data,
    input wire logic ctrl_wr,
    input wire logic [31:0] ctrl_wdata,
    input wire logic direct_interrupt_zero,
    output logic [31:0] int_ctrl,
    output logic [4:0] cur_prio,
    output logic msg_done,
    output logic [31:0] msg_word0,
    output logic svc_now,
    output logic posted,
    output logic [7:0] svc_vector,
    output logic busy
);
    // ------------------------------------------------
    // state and decode
    // ------------------------------------------------
    amm_pkg::amm_state_t st_r;
    logic [1:0] cnt_r;
    logic [31:0] w0_r;
    logic prio_pend_r;
    logic [4:0] new_prio_r;
    logic rd_r, wr_r;
    logic [31:0] addr_r, wdata_r;
    wire [31:0] mbox_addr = processor_index ? amm_pkg::MBOX_ADDR1
                                            : amm_pkg::MBOX_ADDR0;
    wire [31:0] ack_addr = processor_index ? amm_pkg::ACK_ADDR1
                                           : amm_pkg::ACK_ADDR0;
    wire msg_mode = int_ctrl[7:0] == amm_pkg::I0_MSG_SEL;
    wire ext_msg = msg_mode && bus.msg_pin;
    wire [4:0] msg_prio = w0_r[amm_pkg::PRIO_MSB:amm_pkg::PRIO_LSB];
    wire [7:0] msg_vec = w0_r[7:0];
    wire vec_ok = msg_vec >= amm_pkg::VEC_LOW;
    wire [31:0] prio_word = {11'h000, new_prio_r, 12'h000, 4'h8};
    wire [31:0] ack_word = {27'h0, 2'h0, amm_pkg::ACK_CODE};
    wire in_act = st_r == amm_pkg::AMM_ACT;
    wire higher = msg_prio > cur_prio;
    wire take_int = in_act && vec_ok;
    wire raise_prio = take_int && higher;
    wire in_idle = st_r == amm_pkg::AMM_IDLE;
    // a new priority event defers the mirror write to carry the latest
    wire mirror_go = in_idle && !self_msg && !ext_msg && prio_pend_r
                     && !prio_event;
    assign bus.rd = rd_r;
    assign bus.wr = wr_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
    // ------------------------------------------------
    // sequencer
    // ------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= amm_pkg::AMM_IDLE;
            cnt_r <= 2'h0;
            w0_r <= 32'h0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 32'h0;
            wdata_r <= 32'h0;
            busy <= 1'b0;
        end else if (clk_en) begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            case (st_r)
                amm_pkg::AMM_IDLE: begin
                    busy <= 1'b0;
                    if (self_msg) begin
                        w0_r <= self_msg_data;
                        st_r <= amm_pkg::AMM_ACT;
                        busy <= 1'b1;
                    end else if (ext_msg) begin
                        rd_r <= 1'b1;
                        addr_r <= mbox_addr;
                        cnt_r <= 2'h0;
                        busy <= 1'b1;
                        st_r <= amm_pkg::AMM_READ;
                    end else if (mirror_go) begin
                        wr_r <= 1'b1;
                        addr_r <= ack_addr;
                        wdata_r <= prio_word;
                    end
                end
                amm_pkg::AMM_READ: begin
                    if (bus.rvalid) begin
                        if (cnt_r == 2'h0) begin
                            w0_r <= bus.rdata;
                        end
                        cnt_r <= cnt_r + 2'h1;
                        if (cnt_r == 2'(amm_pkg::MBOX_WORDS - 1)) begin
                            st_r <= amm_pkg::AMM_ACK;
                        end
                    end
                end
                amm_pkg::AMM_ACK: begin
                    wr_r <= 1'b1;
                    addr_r <= ack_addr;
                    wdata_r <= ack_word;
                    st_r <= amm_pkg::AMM_ACT;
                end
                amm_pkg::AMM_ACT: begin
                    st_r <= amm_pkg::AMM_PRIO;
                end
                // one spare cycle lets the released pin read low before idle
                amm_pkg::AMM_PRIO: begin
                    st_r <= amm_pkg::AMM_IDLE;
                end
                default: begin
                    st_r <= amm_pkg::AMM_IDLE;
                end
            endcase
        end
    end
    // ------------------------------------------------
    // interrupt control setting
    // ------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            int_ctrl <= amm_pkg::INT_CTRL_RST;
        end else if (clk_en && ctrl_wr) begin
            int_ctrl <= ctrl_wdata;
        end
    end
    // ------------------------------------------------
    // running priority and its external mirror
    // ------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cur_prio <= 5'h00;
            prio_pend_r <= 1'b0;
            new_prio_r <= 5'h00;
        end else if (clk_en) begin
            if (mirror_go) begin
                prio_pend_r <= 1'b0;
            end
            if (prio_event) begin
                cur_prio <= prio_event_val;
                if (mirror_en) begin
                    prio_pend_r <= 1'b1;
                    new_prio_r <= prio_event_val;
                end
            end
            if (raise_prio) begin
                cur_prio <= msg_prio;
                if (ext_msg_en) begin
                    prio_pend_r <= 1'b1;
                    new_prio_r <= msg_prio;
                end
            end
        end
    end
    // ------------------------------------------------
    // message results
    // ------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            msg_done <= 1'b0;
            msg_word0 <= 32'h0;
            svc_now <= 1'b0;
            posted <= 1'b0;
            svc_vector <= 8'h00;
        end else if (clk_en) begin
            msg_done <= in_act;
            svc_now <= take_int && higher;
            posted <= take_int && !higher;
            if (in_act) begin
                msg_word0 <= w0_r;
            end
            if (take_int) begin
                svc_vector <= msg_vec;
            end
        end
    end
    // direct_interrupt_zero is unused in every mode; it only feeds unused_ok
    wire unused_ok = direct_interrupt_zero;
endmodule
`default_nettype wire

/* File: core/amm_other.sv */
`timescale 1ns/1ps
`default_nettype none
module amm_other (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    amm_if.other bus,
    input wire logic processor_index,
    input wire logic send,
    input wire logic [31:0] send_word,
    input wire logic [4:0] send_prio,
    input wire logic filter_en,
    output logic [4:0] ext_prio,
    output logic refused,
    output logic pin_level
);
    // ------------------------------------------------
    // mailbox and decode
    // ------------------------------------------------
    logic [31:0] mbox_r [amm_pkg::MBOX_WORDS];
    logic [1:0] wptr_r, rptr_r;
    logic rd_act_r, pin_r, rv_r;
    logic [31:0] rdata_r;
    wire [31:0] mbox_addr = processor_index ? amm_pkg::MBOX_ADDR1
                                            : amm_pkg::MBOX_ADDR0;
    wire [31:0] ack_addr = processor_index ? amm_pkg::ACK_ADDR1
                                           : amm_pkg::ACK_ADDR0;
    wire hit_ack = bus.wr && bus.addr == ack_addr;
    wire is_prio = hit_ack && bus.wdata[amm_pkg::PRIO_FLAG_BIT];
    wire is_ack = hit_ack && bus.wdata[2:0] == amm_pkg::ACK_CODE;
    wire low = filter_en && send_prio <= ext_prio;
    wire take = send && !low;
    assign bus.msg_pin = pin_r;
    assign bus.rdata = rdata_r;
    assign bus.rvalid = rv_r;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < amm_pkg::MBOX_WORDS; i++) begin
                mbox_r[i] <= 32'h0;
            end
            wptr_r <= 2'h0;
            rptr_r <= 2'h0;
            rd_act_r <= 1'b0;
            rv_r <= 1'b0;
            rdata_r <= 32'h0;
            pin_r <= 1'b0;
            pin_level <= 1'b0;
            ext_prio <= 5'h00;
            refused <= 1'b0;
        end else if (clk_en) begin
            refused <= send && low;
            rv_r <= 1'b0;
            if (take) begin
                mbox_r[wptr_r] <= send_word;
                wptr_r <= wptr_r + 2'h1;
                if (wptr_r == 2'(amm_pkg::MBOX_WORDS - 1)) begin
                    pin_r <= 1'b1;
                    pin_level <= 1'b1;
                end
            end
            if (bus.rd && bus.addr == mbox_addr) begin
                rd_act_r <= 1'b1;
                rptr_r <= 2'h0;
            end else if (rd_act_r) begin
                rv_r <= 1'b1;
                rdata_r <= mbox_r[rptr_r];
                rptr_r <= rptr_r + 2'h1;
                if (rptr_r == 2'(amm_pkg::MBOX_WORDS - 1)) begin
                    rd_act_r <= 1'b0;
                end
            end
            if (is_prio) begin
                ext_prio <= bus.wdata[amm_pkg::PRIO_MSB:amm_pkg::PRIO_LSB];
            end
            if (is_ack && !(take && wptr_r == 2'h3)) begin
                pin_r <= 1'b0;
                pin_level <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/amm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module amm_monitor (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic processor_index,
    input wire logic rd,
    input wire logic wr,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic rvalid,
    input wire logic msg_pin
);
    // ---
    // mailbox fetch and acknowledge
    // ---
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire logic is_ack = wr && (wdata[2:0] == amm_pkg::ACK_CODE);
    sequence burst_s;
        ##1 !rvalid ##1 rvalid [*4];
    endsequence
    sequence ack_s;
        ##1 !wr ##1 (is_ack && !rvalid);
    endsequence
    burst_read_a: assert property (rd |-> burst_s)
        else $error("mailbox burst malformed");
    ack_follow_a: assert property (rd |-> burst_s ##0 ack_s)
        else $error("acknowledge missing after burst");
    single_burst_a: assert property (rd |=> (!rd) [*6])
        else $error("second read inside burst");
    read_cause_a: assert property (rd |-> msg_pin)
        else $error("read without message pin");
    mbox_addr_a: assert property (rd |-> addr == (processor_index ?
        amm_pkg::MBOX_ADDR1 : amm_pkg::MBOX_ADDR0))
        else $error("mailbox address wrong");
    ack_addr_a: assert property (wr |-> addr == (processor_index ?
        amm_pkg::ACK_ADDR1 : amm_pkg::ACK_ADDR0))
        else $error("reserved address wrong");
    write_kind_a: assert property (wr |-> wdata[3] != is_ack)
        else $error("write kind ambiguous");
    pin_release_a: assert property (is_ack |=> !msg_pin)
        else $error("pin kept after acknowledge");
    pin_hold_a: assert property (msg_pin && !is_ack |=> msg_pin)
        else $error("pin dropped early");
endmodule
`default_nettype wire

/* File: testbench/amm_agent_message_mailbox_priority_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module amm_agent_message_mailbox_priority_bench;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic idx = 1'b0;
    logic prio_event = 1'b0;
    logic [4:0] prio_val = 5'h00;
    logic self_msg = 1'b0;
    logic ctrl_wr = 1'b0;
    logic [31:0] ctrl_wdata = 32'h0;
    logic send = 1'b0;
    logic [31:0] send_word = 32'h0;
    logic [4:0] send_prio = 5'h00;
    logic filter_en = 1'b0;
    logic [31:0] int_ctrl, msg_word0, seed;
    logic [4:0] cur_prio, ext_prio;
    logic msg_done, svc_now, posted, refused, pin_level, busy, ok, now, pst;
    logic [7:0] svc_vector;
    int failures = 0;
    int checks = 0;
    int rd_cnt = 0;
    int ref_cnt = 0;
    int r0;
    amm_if bus_if ();
    amm_device amm_device_i (.ref_clk, .resetn, .clk_en, .bus(bus_if),
        .processor_index(idx), .mirror_en(1'b1), .ext_msg_en(1'b1),
        .prio_event, .prio_event_val(prio_val), .self_msg,
        .self_msg_data(32'h001f0020), .ctrl_wr, .ctrl_wdata,
        .direct_interrupt_zero(1'b0), .int_ctrl, .cur_prio, .msg_done,
        .msg_word0, .svc_now, .posted, .svc_vector, .busy);
    amm_other amm_other_i (.ref_clk, .resetn, .clk_en, .bus(bus_if),
        .processor_index(idx), .send, .send_word, .send_prio, .filter_en,
        .ext_prio, .refused, .pin_level);
    amm_monitor amm_monitor_i (.ref_clk, .resetn, .processor_index(idx),
        .rd(bus_if.rd), .wr(bus_if.wr), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .rvalid(bus_if.rvalid),
        .msg_pin(bus_if.msg_pin));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (bus_if.rd === 1'b1) rd_cnt <= rd_cnt + 1;
        if (refused === 1'b1) ref_cnt <= ref_cnt + 1;
    end
    // ---
    // helpers
    // ---
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic pulse_ctrl(input logic [31:0] v);
        @(posedge ref_clk);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= v;
        @(posedge ref_clk);
        ctrl_wr <= 1'b0;
    endtask
    task automatic send_msg(input logic [31:0] w0);
        for (int k = 0; k < amm_pkg::MBOX_WORDS; k++) begin
            @(posedge ref_clk);
            send <= 1'b1;
            send_word <= (k == 0) ? w0 : seed;
            send_prio <= w0[20:16];
            seed = xs(seed);
        end
        @(posedge ref_clk);
        send <= 1'b0;
    endtask
    task automatic wait_done();
        ok = 1'b0;
        for (int n = 0; n < 100 && !ok; n++) begin
            @(posedge ref_clk);
            #1;
            ok = (msg_done === 1'b1);
            now = svc_now;
            pst = posted;
        end
    endtask
    task automatic run_msg(input logic [31:0] w0);
        logic [4:0] cp;
        cp = cur_prio;
        send_msg(w0);
        wait_done();
        chk(ok, 1'b1);
        chk(msg_word0, w0);
        chk(svc_vector, w0[7:0]);
        chk(now, w0[20:16] > cp);
        chk(pst, w0[20:16] <= cp);
    endtask
    // ---
    // scenarios
    // ---
    initial begin
        seed = 32'h9b6a;
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            resetn <= 1'b0;
            idx <= i[0];
            repeat (12) @(posedge ref_clk);
            resetn <= 1'b1;
            @(posedge ref_clk);
            #1;
            chk(int_ctrl, amm_pkg::INT_CTRL_RST);
            chk(cur_prio, 5'h00);
            @(posedge ref_clk);
            prio_event <= 1'b1;
            prio_val <= 5'h10;
            @(posedge ref_clk);
            prio_event <= 1'b0;
            for (int n = 0; n < 50 && ext_prio !== 5'h10; n++) begin
                @(posedge ref_clk);
            end
            #1;
            chk(ext_prio, 5'h10);
            run_msg(32'h00110008);
            run_msg({11'h0, cur_prio, 16'h00ff});
            for (int k = 0; k < 3; k++) begin
                seed = xs(seed);
                run_msg({11'h0, seed[20:16], 8'h00, 8'h08 | seed[7:0]});
            end
            r0 = ref_cnt;
            @(posedge ref_clk);
            filter_en <= 1'b1;
            send_msg({11'h0, ext_prio, 16'h0008});
            repeat (2) @(posedge ref_clk);
            #1;
            chk(ref_cnt > r0, 1'b1);
            chk(pin_level, 1'b0);
            @(posedge ref_clk);
            filter_en <= 1'b0;
            r0 = rd_cnt;
            @(posedge ref_clk);
            self_msg <= 1'b1;
            @(posedge ref_clk);
            self_msg <= 1'b0;
            wait_done();
            chk(ok, 1'b1);
            chk(rd_cnt, r0);
            pulse_ctrl(amm_pkg::INT_CTRL_RST | 32'h05);
            send_msg(32'h00050040);
            wait_done();
            chk(ok, 1'b0);
            chk(busy, 1'b0);
            chk(pin_level, 1'b1);
            chk(int_ctrl, 32'hff000005);
            @(posedge ref_clk);
            clk_en <= 1'b0;
            pulse_ctrl(amm_pkg::INT_CTRL_RST);
            #1;
            chk(int_ctrl, 32'hff000005);
            chk(pin_level, 1'b1);
            @(posedge ref_clk);
            clk_en <= 1'b1;
            pulse_ctrl(amm_pkg::INT_CTRL_RST);
            wait_done();
            chk(ok, 1'b1);
            chk(msg_word0, 32'h00050040);
        end
        stop_test();
    end
    initial begin
        #200000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
